// ==== core/dhis_pkg.sv ====
package dhis_pkg;
    typedef enum logic [1:0] {
        DHIS_SERIAL,
        DHIS_M6800,
        DHIS_TWOWIRE,
        DHIS_I8080
    } dhis_mode_t;

    localparam int         DHIS_W        = 8;
    localparam int         CLK_NS        = 20;
    localparam int         STB_NS        = 140;
    localparam int         REC_NS        = 160;
    localparam int         SCK_HALF_NS   = 100;
    localparam int         STB_CYC       = (STB_NS + CLK_NS - 1) / CLK_NS;
    localparam int         REC_CYC       = (REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int         SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int         SCLK_BIT      = 0;
    localparam int         SERIAL_DATA_IN_BIT      = 1;
    localparam logic       SEL_FIRST_DEF = 1'b1;
    localparam logic       SEL_SECOND_DEF = 1'b1;
    localparam logic [7:0] BUS_IDLE      = 8'hff;

    // mode decode, first pin listed first
    function automatic dhis_mode_t dhis_decode(input logic first, input logic second);
        unique case ({first, second})
            2'b01:   dhis_decode = DHIS_M6800;
            2'b11:   dhis_decode = DHIS_I8080;
            2'b10:   dhis_decode = DHIS_TWOWIRE;
            default: dhis_decode = DHIS_SERIAL;
        endcase
    endfunction : dhis_decode
endpackage : dhis_pkg

// ==== core/dhis_if.sv ====
interface dhis_if;
    logic       chip_sel_n;
    logic       data_command_select;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       chip_reset_n;
    logic       iface_sel_first;
    logic       iface_sel_second;
    logic [7:0] host_dout;
    logic       host_oe;
    logic [7:0] dev_dout;
    logic       dev_oe;
    logic [7:0] host_data_bus;

    // Pulled high when nobody drives
    assign host_data_bus = host_oe ? host_dout : (dev_oe ? dev_dout : dhis_pkg::BUS_IDLE);

    modport host (
        output chip_sel_n, data_command_select, write_strobe_n, read_strobe_n,
        output chip_reset_n, iface_sel_first, iface_sel_second, host_dout, host_oe,
        input  host_data_bus
    );
    modport dev (
        input  chip_sel_n, data_command_select, write_strobe_n, read_strobe_n,
        input  chip_reset_n, iface_sel_first, iface_sel_second, host_data_bus,
        output dev_dout, dev_oe
    );
endinterface : dhis_if

// ==== core/dhis_dev.sv ====
module dhis_dev (
    input  wire logic                clk_in,
    input  wire logic                srst_in,
    dhis_if.dev                      pins,
    input  wire logic [7:0]          disp_byte_in,
    input  wire logic [7:0]          status_byte_in,
    output logic                     wr_valid_out,
    output logic                     wr_is_data_out,
    output logic [7:0]               wr_byte_out,
    output logic                     rd_req_out,
    output logic                     rd_is_data_out,
    output logic                     init_out,
    output dhis_pkg::dhis_mode_t     mode_out
);
    typedef struct packed {
        dhis_pkg::dhis_mode_t mode;
        logic                 init;
        logic                 wr_q;
        logic                 rd_q;
        logic                 sck_q;
        logic [7:0]           shreg;
        logic [2:0]           bitn;
        logic [7:0]           pipe;
        logic                 wr_v;
        logic                 wr_dc;
        logic [7:0]           wr_byte;
        logic                 rd_req;
        logic                 rd_dc;
        logic [7:0]           dout;
        logic                 doe;
    } dhis_dev_st_t;

    dhis_dev_st_t s;
    dhis_dev_st_t next_s;

    logic       sel;
    logic       dc;
    logic [7:0] bus;
    logic       wr_n;
    logic       rd_n;
    logic       sck;

    assign sel  = !pins.chip_sel_n;
    assign dc   = pins.data_command_select;
    assign bus  = pins.host_data_bus;
    assign wr_n = pins.write_strobe_n;
    assign rd_n = pins.read_strobe_n;
    assign sck  = bus[dhis_pkg::SCLK_BIT];

    always_comb begin
        next_s        = s;
        // pins sampled every cycle, assumed static
        next_s.mode   = dhis_pkg::dhis_decode(pins.iface_sel_first, pins.iface_sel_second);
        next_s.init   = 1'b0;
        next_s.wr_q   = wr_n;
        next_s.rd_q   = rd_n;
        next_s.sck_q  = sck;
        next_s.wr_v   = 1'b0;
        next_s.rd_req = 1'b0;
        next_s.doe    = 1'b0;
        unique case (s.mode)
            dhis_pkg::DHIS_I8080: begin
                // byte taken on write strobe rise
                if (sel && wr_n && !s.wr_q) begin
                    next_s.wr_v    = 1'b1;
                    next_s.wr_dc   = dc;
                    next_s.wr_byte = bus;
                end
                // read cycle while read strobe low
                if (sel && !rd_n) begin
                    // device drives bus only for reads
                    next_s.doe = 1'b1;
                    if (s.rd_q) begin
                        next_s.dout = dc ? s.pipe : status_byte_in;
                    end
                end
                // Read ends on rising strobe; data reads refill the pipe
                if (sel && rd_n && !s.rd_q) begin
                    next_s.rd_req = 1'b1;
                    next_s.rd_dc  = dc;
                    if (dc) begin
                        next_s.pipe = disp_byte_in;
                    end
                end
            end
            dhis_pkg::DHIS_M6800: begin
                // enable high with select starts cycle
                // write strobe pin high means read
                if (sel && rd_n && wr_n) begin
                    next_s.doe = 1'b1;
                    if (!s.rd_q) begin
                        next_s.dout = dc ? s.pipe : status_byte_in;
                    end
                end
                if (sel && !rd_n && s.rd_q) begin
                    if (wr_n) begin
                        next_s.rd_req = 1'b1;
                        next_s.rd_dc  = dc;
                        if (dc) begin
                            next_s.pipe = disp_byte_in;
                        end
                    end else begin
                        next_s.wr_v    = 1'b1;
                        next_s.wr_dc   = dc;
                        next_s.wr_byte = bus;
                    end
                end
            end
            dhis_pkg::DHIS_SERIAL: begin
                // Deselect restarts byte framing
                if (!sel) begin
                    next_s.bitn = 3'h0;
                end else if (sck && !s.sck_q) begin
                    // shift MSB first on rising clock
                    next_s.shreg = {s.shreg[6:0], bus[dhis_pkg::SERIAL_DATA_IN_BIT]};
                    next_s.bitn  = s.bitn + 3'h1;
                    if (s.bitn == 3'h7) begin
                        next_s.wr_v    = 1'b1;
                        next_s.wr_dc   = dc;
                        next_s.wr_byte = {s.shreg[6:0], bus[dhis_pkg::SERIAL_DATA_IN_BIT]};
                    end
                end
            end
            dhis_pkg::DHIS_TWOWIRE: begin
                // Two-wire protocol not carried; bus left alone
                next_s.bitn = 3'h0;
            end
        endcase
        if (srst_in || !pins.chip_reset_n) begin
            next_s      = '0;
            next_s.mode = dhis_pkg::dhis_decode(pins.iface_sel_first, pins.iface_sel_second);
            next_s.init = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        s <= next_s;
    end

    assign pins.dev_dout  = s.dout;
    assign pins.dev_oe    = s.doe;
    assign wr_valid_out   = s.wr_v;
    assign wr_is_data_out = s.wr_dc;
    assign wr_byte_out    = s.wr_byte;
    assign rd_req_out     = s.rd_req;
    assign rd_is_data_out = s.rd_dc;
    assign init_out       = s.init;
    assign mode_out       = s.mode;
endmodule : dhis_dev

// ==== core/dhis_host.sv ====
module dhis_host #(
    parameter logic SEL_FIRST  = dhis_pkg::SEL_FIRST_DEF,
    parameter logic SEL_SECOND = dhis_pkg::SEL_SECOND_DEF
) (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    dhis_if.host            pins,
    input  wire logic       req_valid_in,
    input  wire logic       req_write_in,
    input  wire logic       req_is_data_in,
    input  wire logic [7:0] req_byte_in,
    input  wire logic       chip_reset_in,
    output logic            req_ready_out,
    output logic            done_out,
    output logic [7:0]      rd_byte_out
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} dhis_hst_t;

    typedef struct packed {
        dhis_hst_t  st;
        logic [7:0] cnt;
        logic [2:0] bitn;
        logic       wr;
        logic       dc;
        logic [7:0] sh;
        logic       dummy;
        logic       need_dummy;
        logic       cs_n;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] dout;
        logic       oe;
        logic       done;
        logic [7:0] rbyte;
        logic       rst_n;
    } dhis_host_st_t;

    localparam logic [7:0] STB_C = 8'(dhis_pkg::STB_CYC - 1);
    localparam logic [7:0] REC_C = 8'(dhis_pkg::REC_CYC - 1);
    localparam logic [7:0] SCK_C = 8'(dhis_pkg::SCK_HALF_CYC - 1);
    localparam dhis_pkg::dhis_mode_t MODE = dhis_pkg::dhis_decode(SEL_FIRST, SEL_SECOND);

    dhis_host_st_t s;
    dhis_host_st_t next_s;
    logic          m68;
    logic          ser;
    logic          take;

    assign m68  = (MODE == dhis_pkg::DHIS_M6800);
    assign ser  = (MODE == dhis_pkg::DHIS_SERIAL);
    assign req_ready_out = (s.st == H_IDLE) && s.rst_n && (MODE != dhis_pkg::DHIS_TWOWIRE)
                           && !(ser && !req_write_in);
    assign take = req_valid_in && req_ready_out;

    always_comb begin
        next_s       = s;
        next_s.done  = 1'b0;
        next_s.rst_n = !chip_reset_in;
        unique case (s.st)
            H_IDLE: begin
                if (take) begin
                    next_s.st    = H_SETUP;
                    next_s.wr    = req_write_in;
                    next_s.dc    = req_is_data_in;
                    next_s.sh    = req_byte_in;
                    next_s.bitn  = 3'h0;
                    next_s.cs_n  = 1'b0;
                    next_s.oe    = req_write_in || ser;
                    next_s.dout  = ser ? {6'h0, req_byte_in[7], 1'b0} : req_byte_in;
                    next_s.wr_n  = m68 ? !req_write_in : 1'b1;
                    next_s.dummy = req_is_data_in && !req_write_in && s.need_dummy;
                end
            end
            H_SETUP: begin
                next_s.st  = H_STROBE;
                next_s.cnt = ser ? SCK_C : STB_C;
                if (m68) begin
                    next_s.rd_n = 1'b1;
                end else if (!ser && s.wr) begin
                    next_s.wr_n = 1'b0;
                end else if (!ser) begin
                    next_s.rd_n = 1'b0;
                end
            end
            H_STROBE: begin
                next_s.cnt = s.cnt - 8'h1;
                if (s.cnt == 8'h0) begin
                    next_s.st = H_HOLD;
                    if (ser) begin
                        // rising serial clock on bit 0
                        next_s.cnt  = SCK_C;
                        next_s.dout = {6'h0, s.sh[7], 1'b1};
                    end else begin
                        next_s.cnt  = REC_C;
                        next_s.rd_n = !m68;
                        next_s.wr_n = m68 ? s.wr_n : 1'b1;
                        if (!s.wr) begin
                            next_s.rbyte = pins.host_data_bus;
                        end
                    end
                end
            end
            H_HOLD: begin
                next_s.cnt = s.cnt - 8'h1;
                if (s.cnt == 8'h0) begin
                    if (ser && s.bitn != 3'h7) begin
                        next_s.st   = H_STROBE;
                        next_s.cnt  = SCK_C;
                        next_s.bitn = s.bitn + 3'h1;
                        next_s.sh   = {s.sh[6:0], 1'b0};
                        next_s.dout = {6'h0, s.sh[6], 1'b0};
                    end else if (s.dummy) begin
                        next_s.dummy = 1'b0;
                        next_s.st    = H_SETUP;
                    end else begin
                        next_s.st         = H_IDLE;
                        next_s.cs_n       = 1'b1;
                        next_s.oe         = ser;
                        next_s.wr_n       = 1'b1;
                        next_s.done       = 1'b1;
                        next_s.need_dummy = s.wr || (!s.dc && s.need_dummy);
                    end
                end
            end
        endcase
        if (srst_in || chip_reset_in) begin
            next_s            = '0;
            next_s.cs_n       = 1'b1;
            next_s.wr_n       = 1'b1;
            next_s.rd_n       = !m68;
            next_s.oe         = ser;
            next_s.need_dummy = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        s <= next_s;
    end

    // select pins from parameters, default 8080
    assign pins.iface_sel_first     = SEL_FIRST;
    assign pins.iface_sel_second    = SEL_SECOND;
    assign pins.chip_sel_n          = s.cs_n;
    assign pins.data_command_select = s.dc;
    assign pins.write_strobe_n      = s.wr_n;
    assign pins.read_strobe_n       = s.rd_n;
    assign pins.chip_reset_n        = s.rst_n;
    assign pins.host_dout           = s.dout;
    assign pins.host_oe             = s.oe;
    assign done_out                 = s.done;
    assign rd_byte_out              = s.rbyte;
endmodule : dhis_host

// ==== tb/dhis_props.sv ====
module dhis_props (
    input wire logic       clk_in,
    input wire logic       srst_in,
    input wire logic       chip_sel_n,
    input wire logic       data_command_select,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic       chip_reset_n,
    input wire logic       iface_sel_first,
    input wire logic       iface_sel_second,
    input wire logic [7:0] host_dout,
    input wire logic       host_oe,
    input wire logic [7:0] dev_dout,
    input wire logic       dev_oe,
    input wire logic [7:0] host_data_bus
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_wr_low;
        !write_strobe_n [*7] ##1 write_strobe_n;
    endsequence
    sequence s_dev_drive;
        ##2 (dev_oe && host_data_bus == dev_dout);
    endsequence
    // Reset must act even while the default disable is active
    property p_rst_pin;
        @(posedge clk_in) disable iff (1'b0) srst_in |=> !chip_reset_n && !dev_oe;
    endproperty
    wr_strobe_cs_a: assert property (!write_strobe_n |-> !chip_sel_n)
        else $error("write strobe low without chip select");
    rd_strobe_cs_a: assert property (!read_strobe_n |-> !chip_sel_n)
        else $error("read strobe low without chip select");
    wr_pulse_len_a: assert property ($fell(write_strobe_n) |-> s_wr_low)
        else $error("write strobe low time wrong");
    rd_answer_a: assert property ($fell(read_strobe_n) |-> s_dev_drive)
        else $error("device not driving bus on read");
    dev_only_read_a: assert property (dev_oe |-> $past(!read_strobe_n && !chip_sel_n, 1) && !host_oe)
        else $error("device drives bus outside a read");
    rd_release_a: assert property ($rose(read_strobe_n) |-> ##2 !dev_oe)
        else $error("device holds bus after read");
    wr_data_hold_a: assert property (!write_strobe_n |-> host_oe && $stable(host_dout) && $stable(data_command_select))
        else $error("write byte or select moved in strobe");
    srst_init_a: assert property (p_rst_pin)
        else $error("reset did not reach the pins");
    chip_rst_a: assert property (!chip_reset_n |=> !dev_oe)
        else $error("device drives bus during chip reset");
    def_mode_a: assert property (iface_sel_first && iface_sel_second)
        else $error("default select pins not both high");
endmodule : dhis_props

// ==== tb/dhis_tb.sv ====
module dhis_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Pairs: 8080, 6800, serial, two-wire
    localparam logic [3:0] SEL_F = 4'h9;
    localparam logic [3:0] SEL_S = 4'h3;
    logic                 clk_in;
    logic                 srst_in;
    logic                 req_valid [4];
    logic                 req_write [4];
    logic                 req_dc    [4];
    logic [7:0]           req_byte  [4];
    logic                 chip_rst  [4];
    logic [7:0]           disp      [4];
    logic [7:0]           status    [4];
    logic                 ready     [4];
    logic                 done      [4];
    logic [7:0]           rd_byte   [4];
    logic                 wr_valid  [4];
    logic                 wr_dc     [4];
    logic [7:0]           wr_byte   [4];
    logic                 rd_req    [4];
    logic                 rd_dc     [4];
    logic                 init      [4];
    dhis_pkg::dhis_mode_t mode      [4];
    logic [8:0]           wr_last   [4];
    int                   wr_cnt    [4];
    int                   rd_cnt    [4];
    int                   mismatches;
    int                   checked;
    int                   cycles;
    dhis_if bus[4] ();

    for (genvar g = 0; g < 4; g++) begin : gen_pair
        dhis_dev dhis_dev_i (.clk_in(clk_in), .srst_in(srst_in), .pins(bus[g]), .disp_byte_in(disp[g]),
            .status_byte_in(status[g]), .wr_valid_out(wr_valid[g]), .wr_is_data_out(wr_dc[g]),
            .wr_byte_out(wr_byte[g]), .rd_req_out(rd_req[g]), .rd_is_data_out(rd_dc[g]),
            .init_out(init[g]), .mode_out(mode[g]));
        dhis_host #(.SEL_FIRST(SEL_F[g]), .SEL_SECOND(SEL_S[g])) dhis_host_i (.clk_in(clk_in),
            .srst_in(srst_in), .pins(bus[g]), .req_valid_in(req_valid[g]), .req_write_in(req_write[g]),
            .req_is_data_in(req_dc[g]), .req_byte_in(req_byte[g]), .chip_reset_in(chip_rst[g]),
            .req_ready_out(ready[g]), .done_out(done[g]), .rd_byte_out(rd_byte[g]));
        always @(posedge clk_in) begin
            if (wr_valid[g] === 1'b1) begin
                wr_cnt[g]  <= wr_cnt[g] + 1;
                wr_last[g] <= {wr_dc[g], wr_byte[g]};
            end
            if (rd_req[g] === 1'b1) begin
                rd_cnt[g] <= rd_cnt[g] + 1;
            end
        end
    end

    dhis_props dhis_props_i (.clk_in(clk_in), .srst_in(srst_in), .chip_sel_n(bus[0].chip_sel_n),
        .data_command_select(bus[0].data_command_select), .write_strobe_n(bus[0].write_strobe_n),
        .read_strobe_n(bus[0].read_strobe_n), .chip_reset_n(bus[0].chip_reset_n),
        .iface_sel_first(bus[0].iface_sel_first), .iface_sel_second(bus[0].iface_sel_second),
        .host_dout(bus[0].host_dout), .host_oe(bus[0].host_oe), .dev_dout(bus[0].dev_dout),
        .dev_oe(bus[0].dev_oe), .host_data_bus(bus[0].host_data_bus));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    function automatic dhis_pkg::dhis_mode_t exp_mode(input logic f, input logic s);
        if (f && s) return dhis_pkg::DHIS_I8080;
        if (s) return dhis_pkg::DHIS_M6800;
        if (f) return dhis_pkg::DHIS_TWOWIRE;
        return dhis_pkg::DHIS_SERIAL;
    endfunction : exp_mode

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Hold the request until taken, then wait for completion
    task automatic xfer(input int k, input logic wr, input logic dc, input logic [7:0] b);
        int n;
        n = 0;
        req_valid[k] <= 1'b1;
        req_write[k] <= wr;
        req_dc[k]    <= dc;
        req_byte[k]  <= b;
        do begin
            @(posedge clk_in);
            n++;
        end while (ready[k] !== 1'b1 && n < 50);
        req_valid[k] <= 1'b0;
        do begin
            @(posedge clk_in);
            n++;
        end while (done[k] !== 1'b1 && n < 150);
        check({8'h00, done[k]}, 9'h001);
    endtask : xfer

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        logic [7:0] b;
        logic       dc;
        int         n;
        void'($urandom(15755));
        srst_in = 1'b1;
        cycles = 0;
        foreach (req_valid[k]) begin
            {req_valid[k], req_write[k], req_dc[k], chip_rst[k]} = 4'h0;
            {req_byte[k], disp[k], status[k]} = 24'h000000;
            {wr_cnt[k], rd_cnt[k], wr_last[k]} = '0;
        end
        repeat (20) @(posedge clk_in);
        check({8'h00, init[0]}, 9'h001);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        for (int k = 0; k < 4; k++) begin
            check({7'h00, mode[k]}, {7'h00, exp_mode(SEL_F[k], SEL_S[k])});
            check({8'h00, init[k]}, 9'h000);
        end
        for (int k = 2; k < 4; k++) begin
            req_valid[k] <= 1'b1;
            req_write[k] <= (k == 3);
            repeat (4) begin
                @(posedge clk_in);
                check({8'h00, ready[k]}, 9'h000);
            end
            req_valid[k] <= 1'b0;
        end
        $display("test modes done");
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 8; i++) begin
                b = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom);
                dc = (i < 2) ? i[0] : 1'($urandom);
                n = wr_cnt[k];
                xfer(k, 1'b1, dc, b);
                check(wr_last[k], {dc, b});
                check(9'(wr_cnt[k] - n), 9'h001);
            end
        end
        $display("test writes done");
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            status[k] <= b;
            xfer(k, 1'b0, 1'b0, 8'h00);
            check({1'b0, rd_byte[k]}, {1'b0, b});
            disp[k] <= 8'h5a;
            n = rd_cnt[k];
            xfer(k, 1'b0, 1'b1, 8'h00);
            check({1'b0, rd_byte[k]}, 9'h05a);
            check(9'(rd_cnt[k] - n), 9'h002);
            check({8'h00, rd_dc[k]}, 9'h001);
            disp[k] <= 8'ha5;
            xfer(k, 1'b0, 1'b1, 8'h00);
            check({1'b0, rd_byte[k]}, 9'h05a);
            xfer(k, 1'b0, 1'b1, 8'h00);
            check({1'b0, rd_byte[k]}, 9'h0a5);
            xfer(k, 1'b1, 1'b1, 8'h33);
            disp[k] <= 8'hc3;
            xfer(k, 1'b0, 1'b1, 8'h00);
            check({1'b0, rd_byte[k]}, 9'h0c3);
        end
        $display("test reads done");
        chip_rst[0] <= 1'b1;
        repeat (4) @(posedge clk_in);
        check({8'h00, init[0]}, 9'h001);
        chip_rst[0] <= 1'b0;
        repeat (4) @(posedge clk_in);
        check({8'h00, init[0]}, 9'h000);
        xfer(0, 1'b1, 1'b0, 8'h7e);
        check(wr_last[0], 9'h07e);
        $display("test reset done");
        end_of_test();
    end
endmodule : dhis_tb
